// >>> hdl/charger_alert_defines.svh
// Register map, field positions and reset values of the charger alert block
// Contract
// - Source output over-voltage sets flag 15, interrupt
// - Source output under-voltage sets flag 14, interrupt
// - Charge-mode input over-voltage sets flag 13, interrupt
// - Charge-mode adapter over-voltage sets flag 12, interrupt
// - Source-mode low battery halt sets flag 7
// - Watchdog expiry sets flag 6
// - Safety timer expiry sets flag 5, interrupt
// - Thermal shutdown sets flag 4, interrupt
// - Charge mode thermistor code in bits 2:0
// - Source mode thermistor codes cold/hot/float only
// - Mask bit 1 enables; reset by watchdog
// - Masked sources still set their flags
// - Mask bit layout per source
// - Mode and charge state changes raise events
`ifndef CHARGER_ALERT_DEFINES_SVH
`define CHARGER_ALERT_DEFINES_SVH

// Register indices; byte address is index times four
`define IDX_FAULT_STATUS_ONE 8'h17
`define IDX_ALERT_MASK_ZERO  8'h18
`define IDX_EVENT_STATUS     8'h1a
`define ADDR_IDX_LSB         2
`define ADDR_IDX_MSB         9

// Reset values and writable bits
`define FAULT_STATUS_RESET   16'h0000
`define ALERT_MASK_RESET     16'h0000
`define EVENT_STATUS_RESET   16'h0000
`define ALERT_MASK_RW_BITS   16'h3cff

// Fault status bit positions
`define FS_SRC_OV            15
`define FS_SRC_UV            14
`define FS_IN_OV             13
`define FS_ADP_OV            12
`define FS_BAT_OV            8
`define FS_BAT_LOW           7
`define FS_WDT_EXP           6
`define FS_TMR_EXP           5
`define FS_THERMAL_SHUTDOWN_FLAG        4
`define FS_CODE_MSB          2
`define FS_CODE_LSB          0

// Mask and event status bit positions
`define MK_SRC_FAULT         13
`define MK_IN_OV             12
`define MK_PWR_GOOD          11
`define MK_BAT_OV            10
`define MK_BAT_LOW           7
`define MK_BAT_ABSENT        6
`define MK_THERMAL_SHUTDOWN_FLAG        5
`define MK_TEMP_SENSE        4
`define MK_THERMISTOR        3
`define MK_TIMER             2
`define MK_MODE_CHANGE       1
`define MK_PHASE_CHANGE      0

// Thermistor codes
`define CODE_NORMAL          3'h0
`define CODE_COLD            3'h1
`define CODE_COOL            3'h2
`define CODE_WARM            3'h3
`define CODE_HOT             3'h4
`define CODE_FLOAT           3'h7

// Positions in the synchronised input bundle
`define IN_SRC_OV            0
`define IN_SRC_UV            1
`define IN_IN_OV             2
`define IN_ADP_OV            3
`define IN_BAT_OV            4
`define IN_BAT_LOW           5
`define IN_WDT_EXP           6
`define IN_TMR_EXP           7
`define IN_THERMAL_SHUTDOWN_FLAG        8
`define IN_CODE_LSB          9
`define IN_CODE_MSB          11
`define IN_SOURCE_MODE       12
`define IN_PWR_GOOD          13
`define IN_BAT_ABSENT        14
`define IN_TEMP_SENSE        15
`define IN_MODE_LSB          16
`define IN_MODE_MSB          17
`define IN_PHASE_LSB         18
`define IN_PHASE_MSB         20
`define IN_WIDTH             21

`endif

// >>> hdl/charger_alert_pkg.sv
// Types of the charger alert block
`include "charger_alert_defines.svh"

package charger_alert_pkg;

    typedef logic [`IN_WIDTH-1:0] in_bundle_t;

    typedef struct packed {
        in_bundle_t  in_prev;
        logic [15:0] fault_flags;
        logic [2:0]  thermistor_fault_code;
        logic [15:0] event_flags;
        logic [15:0] alert_mask;
        logic [31:0] rdata;
        logic        irq;
    } alert_state_t;

endpackage

// >>> hdl/charger_fault_alert_logic.sv
// Fault flags, alert masks and interrupt of the charger, behind an APB slave
`timescale 1ns/1ns
`default_nettype none
`include "charger_alert_defines.svh"

module charger_fault_alert_logic
    import charger_alert_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Protection events, asynchronous levels
    input  wire logic        src_out_ov_i,
    input  wire logic        src_out_uv_i,
    input  wire logic        input_ov_i,
    input  wire logic        adapter_ov_i,
    input  wire logic        battery_ov_i,
    input  wire logic        battery_low_i,
    input  wire logic        watchdog_timer_expired_i,
    input  wire logic        safety_timer_expired_i,
    input  wire logic        thermal_shutdown_i,
    input  wire logic [2:0]  thermistor_code_i,
    input  wire logic        source_mode_i,
    // Status sources, asynchronous levels
    input  wire logic        power_good_i,
    input  wire logic        battery_absent_i,
    input  wire logic        temp_sense_fault_i,
    input  wire logic [1:0]  converter_mode_i,
    input  wire logic [2:0]  charge_phase_i,
    // Interrupt
    output logic             irq_o
);

    logic [1:0]   rst_sync_reg;
    logic         rst_n;
    alert_state_t st_reg;
    alert_state_t st_next;
    in_bundle_t   cur;
    in_bundle_t   rise;
    logic [7:0]   idx;
    logic         hit;
    logic         access;
    logic         setup;
    logic [2:0]   code_in;
    logic [2:0]   code_ok;
    logic [15:0]  fault_set;
    logic [15:0]  event_set;
    logic [15:0]  pending;
    logic         clr_fault;
    logic         clr_event;
    logic         aligned;
    logic         in_range;
    logic         rd_setup;
    logic         mask_wr;
    logic [15:0]  fault_view;
    logic [15:0]  event_view;
    logic [2:0]   code_view;
    logic [2:0]   code_next;
    logic [15:0]  mask_next;
    logic [31:0]  rdata_sel;

    sync_if #(.WIDTH(`IN_WIDTH)) pins ();

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync_reg <= 2'h0;
        end
        else if (clk_en_i)
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // Asynchronous pins into the synchroniser
    assign pins.raw = {charge_phase_i, converter_mode_i, temp_sense_fault_i,
                       battery_absent_i, power_good_i, source_mode_i,
                       thermistor_code_i, thermal_shutdown_i,
                       safety_timer_expired_i, watchdog_timer_expired_i,
                       battery_low_i, battery_ov_i, adapter_ov_i, input_ov_i,
                       src_out_uv_i, src_out_ov_i};

    pin_sync #(.WIDTH(`IN_WIDTH)) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .clk_en_i  (clk_en_i),
        .pins      (pins.sink)
    );

    // Rising edges and address decode
    assign cur    = pins.synced;
    assign rise   = cur & ~st_reg.in_prev;
    assign idx    = paddr_i[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign aligned  = paddr_i[1:0] == 2'h0;
    assign in_range = paddr_i[11:10] == 2'h0;
    assign hit    = aligned && in_range
                    && ((idx == `IDX_FAULT_STATUS_ONE)
                    || (idx == `IDX_ALERT_MASK_ZERO)
                    || (idx == `IDX_EVENT_STATUS));
    assign access = psel_i && penable_i;
    assign setup  = psel_i && !penable_i;
    assign code_in = cur[`IN_CODE_MSB:`IN_CODE_LSB];

    always_comb
    begin
        code_ok = `CODE_NORMAL;
        if (!cur[`IN_SOURCE_MODE])
        begin
            if ((code_in <= `CODE_HOT) || (code_in == `CODE_FLOAT))
            begin
                code_ok = code_in;
            end
        end
        else if ((code_in == `CODE_COLD) || (code_in == `CODE_HOT)
                 || (code_in == `CODE_FLOAT))
        begin
            code_ok = code_in;
        end
    end

    // Fault events; all but watchdog, timer and thermal are mode qualified
    always_comb
    begin
        fault_set = 16'h0000;
        fault_set[`FS_SRC_OV]     = rise[`IN_SRC_OV] && cur[`IN_SOURCE_MODE];
        fault_set[`FS_SRC_UV]     = rise[`IN_SRC_UV] && cur[`IN_SOURCE_MODE];
        fault_set[`FS_IN_OV]      = rise[`IN_IN_OV] && !cur[`IN_SOURCE_MODE];
        fault_set[`FS_ADP_OV]     = rise[`IN_ADP_OV] && !cur[`IN_SOURCE_MODE];
        fault_set[`FS_BAT_OV]     = rise[`IN_BAT_OV] && !cur[`IN_SOURCE_MODE];
        fault_set[`FS_BAT_LOW]    = rise[`IN_BAT_LOW] && cur[`IN_SOURCE_MODE];
        fault_set[`FS_WDT_EXP]    = rise[`IN_WDT_EXP];
        fault_set[`FS_TMR_EXP]    = rise[`IN_TMR_EXP];
        fault_set[`FS_THERMAL_SHUTDOWN_FLAG] = rise[`IN_THERMAL_SHUTDOWN_FLAG];
    end

    // Status change events
    always_comb
    begin
        event_set = 16'h0000;
        event_set[`MK_PWR_GOOD]   = rise[`IN_PWR_GOOD];
        event_set[`MK_BAT_ABSENT] = rise[`IN_BAT_ABSENT];
        event_set[`MK_TEMP_SENSE] = rise[`IN_TEMP_SENSE];
        event_set[`MK_MODE_CHANGE] = cur[`IN_MODE_MSB:`IN_MODE_LSB]
                                     != st_reg.in_prev[`IN_MODE_MSB:`IN_MODE_LSB];
        event_set[`MK_PHASE_CHANGE] = cur[`IN_PHASE_MSB:`IN_PHASE_LSB]
                                      != st_reg.in_prev[`IN_PHASE_MSB:`IN_PHASE_LSB];
    end

    always_comb
    begin
        pending = st_reg.event_flags;
        pending[`MK_SRC_FAULT]  = st_reg.fault_flags[`FS_SRC_OV]
                                  || st_reg.fault_flags[`FS_SRC_UV];
        pending[`MK_IN_OV]      = st_reg.fault_flags[`FS_IN_OV]
                                  || st_reg.fault_flags[`FS_ADP_OV];
        pending[`MK_BAT_OV]     = st_reg.fault_flags[`FS_BAT_OV];
        pending[`MK_BAT_LOW]    = st_reg.fault_flags[`FS_BAT_LOW];
        pending[`MK_THERMAL_SHUTDOWN_FLAG] = st_reg.fault_flags[`FS_THERMAL_SHUTDOWN_FLAG];
        pending[`MK_THERMISTOR] = st_reg.thermistor_fault_code != `CODE_NORMAL;
        pending[`MK_TIMER]      = st_reg.fault_flags[`FS_TMR_EXP];
    end

    // Bus decode of the current access
    assign rd_setup  = setup && !pwrite_i;
    assign mask_wr   = access && pwrite_i && hit && (idx == `IDX_ALERT_MASK_ZERO);
    assign clr_fault = access && !pwrite_i && (idx == `IDX_FAULT_STATUS_ONE) && hit;
    assign clr_event = access && !pwrite_i && (idx == `IDX_EVENT_STATUS) && hit;

    // Read view takes in events landing in the setup cycle
    always_comb
    begin
        fault_view = st_reg.fault_flags | fault_set;
        event_view = st_reg.event_flags | event_set;
        code_view  = st_reg.thermistor_fault_code;
        if (code_ok != `CODE_NORMAL)
        begin
            code_view = code_ok;
        end
    end

    // Read data multiplexer
    always_comb
    begin
        rdata_sel = 32'h0000_0000;
        if (hit)
        begin
            case (idx)
                `IDX_FAULT_STATUS_ONE:
                begin
                    rdata_sel = {16'h0000, fault_view[15:3], code_view};
                end
                `IDX_ALERT_MASK_ZERO:
                begin
                    rdata_sel = {16'h0000, st_reg.alert_mask};
                end
                `IDX_EVENT_STATUS:
                begin
                    rdata_sel = {16'h0000, event_view};
                end
                default:
                begin
                    rdata_sel = 32'h0000_0000;
                end
            endcase
        end
    end

    // Thermistor code keeps the last valid fault
    always_comb
    begin
        code_next = st_reg.thermistor_fault_code;
        if (code_ok != `CODE_NORMAL)
        begin
            code_next = code_ok;
        end
        else if (clr_fault)
        begin
            code_next = `CODE_NORMAL;
        end
    end

    // Mask register next value
    always_comb
    begin
        mask_next = st_reg.alert_mask;
        if (mask_wr)
        begin
            mask_next = pwdata_i[15:0] & `ALERT_MASK_RW_BITS;
        end
        if (rise[`IN_WDT_EXP])
        begin
            mask_next = `ALERT_MASK_RESET;
        end
    end

    // Next state
    always_comb
    begin
        st_next = st_reg;
        st_next.in_prev = cur;
        st_next.fault_flags = (clr_fault ? `FAULT_STATUS_RESET : st_reg.fault_flags)
                              | fault_set;
        st_next.event_flags = (clr_event ? `EVENT_STATUS_RESET : st_reg.event_flags)
                              | event_set;
        st_next.thermistor_fault_code = code_next;
        st_next.alert_mask = mask_next;
        st_next.irq = |(st_reg.alert_mask & pending);
        if (rd_setup)
        begin
            st_next.rdata = rdata_sel;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else if (clk_en_i)
        begin
            st_reg <= st_next;
        end
    end

    assign prdata_o  = st_reg.rdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = access && !hit;
    assign irq_o     = st_reg.irq;

endmodule

`default_nettype wire

// >>> hdl/pin_sync.sv
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic clk_en_i,
    // Pins in, synchronised out
    sync_if.sink      pins
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t sync_reg;
    sync_state_t sync_next;

    always_comb
    begin
        sync_next        = sync_reg;
        sync_next.stage1 = pins.raw;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_reg <= '0;
        end
        else if (clk_en_i)
        begin
            sync_reg <= sync_next;
        end
    end

    assign pins.synced = sync_reg.stage2;

endmodule

`default_nettype wire

// >>> hdl/sync_if.sv
// Carrier between raw pins and their synchronised copy
`timescale 1ns/1ns
`default_nettype none

interface sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport sink (input raw, output synced);
    modport user (output raw, input synced);
endinterface

`default_nettype wire

// >>> verification/charger_alert_monitor.sv
// Bus and interrupt checks of the charger alert block
`timescale 1ns/1ns
`default_nettype none

module charger_alert_monitor (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    // Bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Pins
    input wire logic        watchdog_timer_expired_i,
    input wire logic        irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic acc;
    logic mwr;
    logic touched_reg;
    assign acc = psel_i && penable_i;
    assign mwr = acc && pwrite_i && paddr_i == 12'h060;

    // Mask written nonzero since reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            touched_reg <= 1'b0;
        else if (mwr && pwdata_i[15:0] != 16'h0000)
            touched_reg <= 1'b1;
    end

    sequence wdt_rise;
        $rose(watchdog_timer_expired_i);
    endsequence
    sequence bus_quiet;
        !psel_i [*6];
    endsequence

    a_ready_always: assert property (pready_o)
        else $error("pready low");
    a_err_access: assert property (!acc |-> !pslverr_o)
        else $error("pslverr outside access");
    a_err_misalign: assert property (acc && paddr_i[1:0] != 2'b00 |-> pslverr_o)
        else $error("misaligned access accepted");
    a_err_upper: assert property (acc && paddr_i[11:10] != 2'b00 |-> pslverr_o)
        else $error("out of range access accepted");
    a_mask_mapped: assert property (mwr |-> !pslverr_o)
        else $error("mask write refused");
    a_upper_zero: assert property (acc && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
        else $error("read data upper half nonzero");
    a_rdata_stands: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
        else $error("read data changed without read");
    a_clear_quiet: assert property (mwr && pwdata_i[15:0] == 16'h0000 ##1 !psel_i |-> ##1 !irq_o)
        else $error("irq with all masked");
    a_default_quiet: assert property (!touched_reg |-> !irq_o)
        else $error("irq with default mask");
    a_wdt_quiet: assert property (wdt_rise ##1 bus_quiet |-> !irq_o)
        else $error("irq after watchdog mask clear");
endmodule

`default_nettype wire

// >>> verification/host_apb_model.sv
// Bus master model of the host processor
`timescale 1ns/1ns
`default_nettype none

module host_apb_model (
    // Clock
    input  wire logic        sys_clk_i,
    // Requests
    output var logic         psel_o,
    output var logic         penable_o,
    output var logic         pwrite_o,
    output var logic [11:0]  paddr_o,
    output var logic [31:0]  pwdata_o,
    // Answers
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i
);
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        do
            @(posedge sys_clk_i);
        while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench of the charger alert block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam logic [8:0] SRC_M = 9'b000100011;
    logic        sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q, d, seed;
    logic        pready_o, pslverr_o, irq_o, e, smode, clk_en;
    logic [8:0]  ev;
    logic [7:0]  st;
    logic [2:0]  code;
    int          errors, check_count;
    int          pos[9] = '{15, 14, 13, 12, 8, 7, 6, 5, 4};
    int          ebit[5] = '{11, 6, 4, 1, 0};
    int          flip[5] = '{0, 1, 2, 3, 5};

    host_apb_model i_host (.sys_clk_i, .psel_o(psel_i), .penable_o(penable_i),
        .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
        .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));

    charger_fault_alert_logic i_dut (.sys_clk_i, .rst_n_i, .clk_en_i(clk_en),
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .src_out_ov_i(ev[0]), .src_out_uv_i(ev[1]), .input_ov_i(ev[2]),
        .adapter_ov_i(ev[3]), .battery_ov_i(ev[4]), .battery_low_i(ev[5]),
        .watchdog_timer_expired_i(ev[6]), .safety_timer_expired_i(ev[7]),
        .thermal_shutdown_i(ev[8]), .thermistor_code_i(code), .source_mode_i(smode),
        .power_good_i(st[0]), .battery_absent_i(st[1]), .temp_sense_fault_i(st[2]),
        .converter_mode_i(st[4:3]), .charge_phase_i(st[7:5]), .irq_o);

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] exp_code(input int i);
        int c;
        c = i & 7;
        if (i > 7 && c != 1 && c != 4 && c != 7)
            return 32'h0;
        if (c == 5 || c == 6)
            return 32'h0;
        return 32'(c);
    endfunction

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
        i_host.xfer(1'b0, a, 32'h0, q, e);
        chk(n, x, q);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dat);
        i_host.xfer(1'b1, a, dat, q, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        $display("watchdog timeout");
        summarize();
    end

    initial
    begin
        {rst_n_i, ev, st, code, smode, errors, check_count} = '0;
        seed = 32'h7c53d4dd;
        clk_en = 1'b1;
        tick(10);
        rst_n_i <= 1'b1;
        tick(5);
        rd(12'h05c, 32'h0, "fault_status_one");
        rd(12'h060, 32'h0, "alert_mask_zero");
        i_host.xfer(1'b0, 12'h070, 32'h0, q, e);
        chk("pslverr_o", 32'h1, 32'(e));
        repeat (4)
        begin
            d = xs();
            wr(12'h060, d);
            rd(12'h060, d & 32'h3cff, "alert_mask_zero");
        end
        $display("register test done");
        for (int i = 0; i < 9; i++)
        begin
            wr(12'h060, 32'h3cff);
            smode <= SRC_M[i];
            tick(4);
            ev[i] <= 1'b1;
            tick(6);
            chk("irq_o", 32'(i != 6), 32'(irq_o));
            rd(12'h05c, 32'h1 << pos[i], "fault_status_one");
            ev[i] <= 1'b0;
            rd(12'h05c, 32'h0, "fault_status_one");
            if (i == 6)
                rd(12'h060, 32'h0, "alert_mask_zero");
            tick(3);
            chk("irq_o", 32'h0, 32'(irq_o));
        end
        wr(12'h060, 32'h0);
        ev[4] <= 1'b1;
        ev[0] <= 1'b1;
        tick(6);
        chk("irq_o", 32'h0, 32'(irq_o));
        rd(12'h05c, 32'h100, "fault_status_one");
        ev[4] <= 1'b0;
        ev[0] <= 1'b0;
        $display("fault test done");
        wr(12'h060, 32'h3cff);
        for (int i = 0; i < 16; i++)
        begin
            smode <= i[3];
            tick(4);
            code <= i[2:0];
            tick(6);
            chk("irq_o", 32'(exp_code(i) != 0), 32'(irq_o));
            code <= 3'h0;
            tick(5);
            rd(12'h05c, exp_code(i), "thermistor_fault_code");
            rd(12'h05c, 32'h0, "fault_status_one");
        end
        $display("thermistor test done");
        for (int i = 0; i < 5; i++)
        begin
            st[flip[i]] <= ~st[flip[i]];
            tick(6);
            chk("irq_o", 32'h1, 32'(irq_o));
            rd(12'h068, 32'h1 << ebit[i], "event_status");
            rd(12'h068, 32'h0, "event_status");
            tick(3);
            chk("irq_o", 32'h0, 32'(irq_o));
        end
        $display("event test done");
        clk_en <= 1'b0;
        ev[8] <= 1'b1;
        tick(6);
        chk("irq_o", 32'h0, 32'(irq_o));
        clk_en <= 1'b1;
        tick(6);
        chk("irq_o", 32'h1, 32'(irq_o));
        rd(12'h05c, 32'h10, "fault_status_one");
        ev[8] <= 1'b0;
        $display("clock enable test done");
        rst_n_i <= 1'b0;
        tick(3);
        rst_n_i <= 1'b1;
        tick(5);
        rd(12'h060, 32'h0, "alert_mask_zero");
        $display("reset test done");
        summarize();
    end
endmodule

bind charger_fault_alert_logic charger_alert_monitor i_mon (.sys_clk_i, .rst_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .watchdog_timer_expired_i, .irq_o);

`default_nettype wire
